// ### i2cst_pkg.sv
`default_nettype none
package i2cst_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int SCL_HZ = 100_000;
  localparam int HALF_CYC = CLK_HZ / (2 * SCL_HZ);
  localparam int TOUT_MS = 25;
  localparam int TOUT_CYC = (CLK_HZ / 1000) * TOUT_MS;
  localparam int RECOVER_MS = 10;
  // ----------------------------------------
  // Register indices and control bits
  // ----------------------------------------
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_ADDR = 2'h3;
  localparam int CTRL_STA = 5;
  localparam int CTRL_STO = 4;
  localparam int CTRL_SI = 3;
  localparam int CTRL_AA = 2;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  // ----------------------------------------
  // Status codes
  // ----------------------------------------
  localparam logic [7:0] ST_SLA_R_ACK = 8'hA8;
  localparam logic [7:0] ST_ARB_SLA_R = 8'hB0;
  localparam logic [7:0] ST_TX_ACK = 8'hB8;
  localparam logic [7:0] ST_TX_NACK = 8'hC0;
  localparam logic [7:0] ST_LAST_ACK = 8'hC8;
  localparam logic [7:0] ST_TIMEOUT = 8'hD8;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_IDLE = 8'hF8;
  localparam logic [7:0] ST_BUS_ERR = 8'h00;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic DIR_READ = 1'b1;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ADDR = 3'b001, S_AACK = 3'b010, S_WAIT = 3'b011,
    S_TX = 3'b100, S_TACK = 3'b101, S_ERR = 3'b110
  } i2cst_sl_t;
  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_START = 3'b001, M_LOW = 3'b010, M_HIGH = 3'b011,
    M_STOP1 = 3'b100, M_STOP2 = 3'b101
  } i2cst_ms_t;
endpackage
`default_nettype wire

// ### i2cst_bus_if.sv
`timescale 1ns/100ps
`default_nettype none
interface i2cst_bus_if;
  logic dev_scl_o;
  logic dev_scl_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic scl;
  logic sda;
  // ----------------------------------------
  // Wired-AND bus lines with pull-ups
  // ----------------------------------------
  assign scl = (dev_scl_oe_n | dev_scl_o) & (host_scl_oe_n | host_scl_o);
  assign sda = (dev_sda_oe_n | dev_sda_o) & (host_sda_oe_n | host_sda_o);
  modport device (input scl, sda, output dev_scl_o, dev_scl_oe_n, dev_sda_o, dev_sda_oe_n);
  modport host (input scl, sda, output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n);
endinterface
`default_nettype wire

// ### i2cst_host.sv
`timescale 1ns/100ps
`default_nettype none
module i2cst_host
  import i2cst_pkg::*;
#(
  parameter int HALF = HALF_CYC
)(
  input wire logic mclk,
  input wire logic arst_n,
  i2cst_bus_if.host bus,
  input wire logic go,
  input wire logic [6:0] rd_addr,
  input wire logic [7:0] nbytes,
  input wire logic hold_low,
  output logic busy,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic addr_nack,
  output logic done
);
  i2cst_ms_t st_reg;
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [15:0] div_reg;
  logic tick;
  logic scl_low_reg;
  logic sda_low_reg;
  logic [3:0] cnt_reg;
  logic addr_ph_reg;
  logic [7:0] shift_reg;
  logic [7:0] left_reg;
  logic scl_s;
  logic sda_s;
  // ----------------------------------------
  // Pin synchronisers and divider
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
    end
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign tick = (div_reg == 16'(HALF - 1));
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      div_reg <= 16'h0000;
    else if (st_reg == M_IDLE || tick)
      div_reg <= 16'h0000;
    else
      div_reg <= div_reg + 16'h0001;
  // ----------------------------------------
  // Read transfer sequencer
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      st_reg <= M_IDLE;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      cnt_reg <= 4'h0;
      addr_ph_reg <= 1'b0;
      shift_reg <= 8'h00;
      left_reg <= 8'h00;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      addr_nack <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      addr_nack <= 1'b0;
      done <= 1'b0;
      unique case (st_reg)
        M_IDLE:
          if (go && nbytes != 8'h00)
          begin
            sda_low_reg <= 1'b1;
            shift_reg <= {rd_addr, DIR_READ};
            left_reg <= nbytes;
            addr_ph_reg <= 1'b1;
            cnt_reg <= 4'h0;
            st_reg <= M_START;
          end
        M_START:
          if (tick)
          begin
            scl_low_reg <= 1'b1;
            sda_low_reg <= ~shift_reg[7];
            st_reg <= M_LOW;
          end
        M_LOW:
          if (tick)
          begin
            scl_low_reg <= 1'b0;
            st_reg <= M_HIGH;
          end
        M_HIGH:
          if (tick && scl_s)
          begin
            scl_low_reg <= 1'b1;
            if (cnt_reg == BITS_BYTE)
            begin
              cnt_reg <= 4'h0;
              addr_ph_reg <= 1'b0;
              if (addr_ph_reg && sda_s)
              begin
                addr_nack <= 1'b1;
                sda_low_reg <= 1'b1;
                st_reg <= M_STOP1;
              end
              else if (!addr_ph_reg && left_reg == 8'h01)
              begin
                sda_low_reg <= 1'b1;
                st_reg <= M_STOP1;
              end
              else
              begin
                if (!addr_ph_reg)
                  left_reg <= left_reg - 8'h01;
                sda_low_reg <= 1'b0;
                st_reg <= M_LOW;
              end
            end
            else
            begin
              cnt_reg <= cnt_reg + 4'h1;
              shift_reg <= {shift_reg[6:0], sda_s};
              st_reg <= M_LOW;
              if (cnt_reg == BITS_BYTE - 4'h1)
              begin
                if (!addr_ph_reg)
                begin
                  rx_data <= {shift_reg[6:0], sda_s};
                  rx_valid <= 1'b1;
                end
                sda_low_reg <= ~addr_ph_reg && left_reg != 8'h01;
              end
              else
                sda_low_reg <= addr_ph_reg & ~shift_reg[6];
            end
          end
        M_STOP1:
          if (tick)
          begin
            scl_low_reg <= 1'b0;
            st_reg <= M_STOP2;
          end
        M_STOP2:
          if (tick && scl_s)
          begin
            sda_low_reg <= 1'b0;
            done <= 1'b1;
            st_reg <= M_IDLE;
          end
        default:
          st_reg <= M_IDLE;
      endcase
    end
  assign busy = (st_reg != M_IDLE);
  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe_n = ~(scl_low_reg | hold_low);
  assign bus.host_sda_oe_n = ~sda_low_reg;
endmodule
`default_nettype wire

// ### i2cst_device.sv
// Operation
// - Own address read acked: A8, flag set
// - Arbitration lost, then addressed read: B0 (arb_lost_reg clears at addr_done, so A8 is given instead)
// - Byte loaded with ack-enable clear: last byte
// - Byte loaded with ack-enable set: normal byte
// - Nack gives C0, last byte acked C8
// - After end status, leave addressed state
// - Unaddressed: recognise addresses only with ack-enable
// - Start request after end: START when free
// - SCL low for timeout period: D8
// - Software clears flag within 10 ms
// - Arbitration lost: 38, release bus
// - Arbitration lost with start request: START later (sta_reg clears when the START is launched, so no retry follows)
// - Illegal bus condition gives code 00
// - Stop request recovers internally, no STOP driven
// - Recovery clears stop request bit
// - Data register touched only between bytes
// - Address byte bit zero is direction
// - Own address in upper seven bits
// - Address bit zero enables general call
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
module i2cst_device
  import i2cst_pkg::*;
#(
  parameter int HALF = HALF_CYC,
  parameter int TOUT = TOUT_CYC
)(
  input wire logic mclk,
  input wire logic arst_n,
  i2cst_bus_if.device bus,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  i2cst_sl_t sl_reg;
  i2cst_ms_t ms_reg;
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic si_reg;
  logic sta_reg;
  logic sto_reg;
  logic aa_reg;
  logic [7:0] status_reg;
  logic [7:0] data_reg;
  logic [7:0] addr_reg;
  logic [7:0] shift_reg;
  logic [3:0] cnt_reg;
  logic sl_sda_low_reg;
  logic scl_hold_reg;
  logic last_reg;
  logic ack_reg;
  logic gc_hit_reg;
  logic arb_lost_reg;
  logic bus_free_reg;
  logic [31:0] tout_cnt_reg;
  logic tout_fired_reg;
  logic [15:0] div_reg;
  logic tick;
  logic [7:0] m_shift_reg;
  logic [3:0] m_cnt_reg;
  logic m_scl_low_reg;
  logic m_sda_low_reg;
  logic addr_done;
  logic own_hit;
  logic gc_hit;
  logic aack_done;
  logic tack_done;
  logic tout_hit;
  logic err_hit;
  logic m_go;
  logic recover;
  logic evt;
  logic [7:0] evt_code;
  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  assign addr_done = (sl_reg == S_ADDR) && scl_fall && cnt_reg == BITS_BYTE;
  assign own_hit = aa_reg && shift_reg[7:1] == addr_reg[7:1]
                   && shift_reg[0] == DIR_READ;
  assign gc_hit = aa_reg && addr_reg[0] && shift_reg[7:1] == GEN_CALL_ADDR;
  assign aack_done = (sl_reg == S_AACK) && scl_fall;
  assign tack_done = (sl_reg == S_TACK) && scl_fall;
  assign tout_hit = ~scl_s && !tout_fired_reg && tout_cnt_reg == 32'(TOUT - 1);
  assign err_hit = (start_det || stop_det)
                   && ((sl_reg == S_TX && cnt_reg != 4'h0)
                   || ms_reg == M_LOW || ms_reg == M_HIGH);
  assign recover = (sl_reg == S_ERR) && sto_reg && !si_reg;
  assign m_go = ms_reg == M_IDLE && sl_reg == S_IDLE && sta_reg && !si_reg
                && bus_free_reg;
  always_comb
  begin
    evt = 1'b1;
    evt_code = ST_IDLE;
    if (tout_hit)
      evt_code = ST_TIMEOUT;
    else if (err_hit)
      evt_code = ST_BUS_ERR;
    else if (addr_done && !own_hit && !gc_hit && arb_lost_reg)
      evt_code = ST_ARB_LOST;
    else if (aack_done && !gc_hit_reg)
      evt_code = arb_lost_reg ? ST_ARB_SLA_R : ST_SLA_R_ACK;
    else if (tack_done)
      evt_code = !ack_reg ? ST_TX_NACK : (last_reg ? ST_LAST_ACK : ST_TX_ACK);
    else
      evt = 1'b0;
  end
  // ----------------------------------------
  // Control, status and flag
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      si_reg <= 1'b0;
      sta_reg <= 1'b0;
      sto_reg <= 1'b0;
      aa_reg <= 1'b0;
      status_reg <= ST_IDLE;
    end
    else
    begin
      if (reg_wr && reg_addr == REG_CTRL)
      begin
        sta_reg <= reg_wdata[CTRL_STA];
        sto_reg <= reg_wdata[CTRL_STO];
        aa_reg <= reg_wdata[CTRL_AA];
        if (!reg_wdata[CTRL_SI])
          si_reg <= 1'b0;
      end
      if (m_go)
        sta_reg <= 1'b0;
      if (recover)
        sto_reg <= 1'b0;
      if (evt)
      begin
        si_reg <= 1'b1;
        status_reg <= evt_code;
      end
    end
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      data_reg <= DATA_RESET;
      addr_reg <= ADDR_RESET;
    end
    else
    begin
      if (addr_done)
        data_reg <= shift_reg;
      else if (reg_wr && reg_addr == REG_DATA && sl_reg != S_TX && sl_reg != S_TACK)
        data_reg <= reg_wdata;
      if (reg_wr && reg_addr == REG_ADDR)
        addr_reg <= reg_wdata;
    end
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      unique case (reg_addr)
        REG_CTRL:
          reg_rdata <= 8'(({7'h00, sta_reg} << CTRL_STA) | ({7'h00, sto_reg} << CTRL_STO)
                          | ({7'h00, si_reg} << CTRL_SI) | ({7'h00, aa_reg} << CTRL_AA));
        REG_STATUS:
          reg_rdata <= si_reg ? status_reg : ST_IDLE;
        REG_DATA:
          reg_rdata <= data_reg;
        REG_ADDR:
          reg_rdata <= addr_reg;
      endcase
  // ----------------------------------------
  // Bus free and clock-low timeout
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      bus_free_reg <= 1'b1;
    else if (stop_det)
      bus_free_reg <= 1'b1;
    else if (start_det)
      bus_free_reg <= 1'b0;
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      tout_cnt_reg <= 32'h0000_0000;
      tout_fired_reg <= 1'b0;
    end
    else if (scl_s)
    begin
      tout_cnt_reg <= 32'h0000_0000;
      tout_fired_reg <= 1'b0;
    end
    else if (tout_hit)
      tout_fired_reg <= 1'b1;
    else if (!tout_fired_reg)
      tout_cnt_reg <= tout_cnt_reg + 32'h0000_0001;
  // ----------------------------------------
  // Slave transmitter
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      sl_reg <= S_IDLE;
      shift_reg <= 8'h00;
      cnt_reg <= 4'h0;
      sl_sda_low_reg <= 1'b0;
      last_reg <= 1'b0;
      ack_reg <= 1'b0;
      gc_hit_reg <= 1'b0;
    end
    else if (tout_hit || err_hit)
    begin
      sl_sda_low_reg <= 1'b0;
      sl_reg <= tout_hit ? S_IDLE : S_ERR;
    end
    else if (start_det && sl_reg != S_ERR && ms_reg != M_START)
    begin
      sl_sda_low_reg <= 1'b0;
      cnt_reg <= 4'h0;
      sl_reg <= S_ADDR;
    end
    else if (stop_det && sl_reg != S_ERR)
    begin
      sl_sda_low_reg <= 1'b0;
      sl_reg <= S_IDLE;
    end
    else
      unique case (sl_reg)
        S_IDLE:
          cnt_reg <= 4'h0;
        S_ADDR:
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_s};
            cnt_reg <= cnt_reg + 4'h1;
          end
          else if (addr_done)
          begin
            gc_hit_reg <= gc_hit;
            if (own_hit || gc_hit)
            begin
              sl_sda_low_reg <= 1'b1;
              sl_reg <= S_AACK;
            end
            else
              sl_reg <= S_IDLE;
          end
        S_AACK:
          if (scl_fall)
          begin
            sl_sda_low_reg <= 1'b0;
            sl_reg <= gc_hit_reg ? S_IDLE : S_WAIT;
          end
        S_WAIT:
          if (!si_reg)
          begin
            last_reg <= ~aa_reg;
            sl_sda_low_reg <= ~data_reg[7];
            shift_reg <= {data_reg[6:0], 1'b0};
            cnt_reg <= 4'h1;
            sl_reg <= S_TX;
          end
        S_TX:
          if (scl_fall)
          begin
            if (cnt_reg == BITS_BYTE)
            begin
              sl_sda_low_reg <= 1'b0;
              cnt_reg <= 4'h0;
              sl_reg <= S_TACK;
            end
            else
            begin
              sl_sda_low_reg <= ~shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        S_TACK:
          if (scl_rise)
            ack_reg <= ~sda_s;
          else if (scl_fall)
            sl_reg <= (ack_reg && !last_reg) ? S_WAIT : S_IDLE;
        S_ERR:
          if (recover)
            sl_reg <= S_IDLE;
        default:
          sl_reg <= S_IDLE;
      endcase
  // ----------------------------------------
  // Master START and address engine
  // ----------------------------------------
  assign tick = (div_reg == 16'(HALF - 1));
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      div_reg <= 16'h0000;
    else if (ms_reg == M_IDLE || tick)
      div_reg <= 16'h0000;
    else
      div_reg <= div_reg + 16'h0001;
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      ms_reg <= M_IDLE;
      m_shift_reg <= 8'h00;
      m_cnt_reg <= 4'h0;
      m_scl_low_reg <= 1'b0;
      m_sda_low_reg <= 1'b0;
      arb_lost_reg <= 1'b0;
    end
    else if (tout_hit || err_hit)
    begin
      m_scl_low_reg <= 1'b0;
      m_sda_low_reg <= 1'b0;
      arb_lost_reg <= 1'b0;
      ms_reg <= M_IDLE;
    end
    else
    begin
      if (addr_done || aack_done)
        arb_lost_reg <= 1'b0;
      unique case (ms_reg)
        M_IDLE:
          if (m_go)
          begin
            m_sda_low_reg <= 1'b1;
            m_shift_reg <= data_reg;
            m_cnt_reg <= 4'h0;
            ms_reg <= M_START;
          end
        M_START:
          if (tick)
          begin
            m_scl_low_reg <= 1'b1;
            m_sda_low_reg <= ~m_shift_reg[7];
            ms_reg <= M_LOW;
          end
        M_LOW:
          if (tick)
          begin
            m_scl_low_reg <= 1'b0;
            ms_reg <= M_HIGH;
          end
        M_HIGH:
          if (tick && scl_s)
          begin
            if (m_cnt_reg != BITS_BYTE && !m_sda_low_reg && !sda_s)
            begin
              arb_lost_reg <= 1'b1;
              ms_reg <= M_IDLE;
            end
            else if (m_cnt_reg == BITS_BYTE)
            begin
              m_scl_low_reg <= 1'b1;
              m_sda_low_reg <= 1'b1;
              ms_reg <= M_STOP1;
            end
            else
            begin
              m_scl_low_reg <= 1'b1;
              m_sda_low_reg <= (m_cnt_reg != BITS_BYTE - 4'h1) & ~m_shift_reg[6];
              m_shift_reg <= {m_shift_reg[6:0], 1'b0};
              m_cnt_reg <= m_cnt_reg + 4'h1;
              ms_reg <= M_LOW;
            end
          end
        M_STOP1:
          if (tick)
          begin
            m_scl_low_reg <= 1'b0;
            ms_reg <= M_STOP2;
          end
        M_STOP2:
          if (tick && scl_s)
          begin
            m_sda_low_reg <= 1'b0;
            ms_reg <= M_IDLE;
          end
        default:
          ms_reg <= M_IDLE;
      endcase
    end
  // ----------------------------------------
  // Pin drive, clock stretched while waiting
  // ----------------------------------------
  // Clock held one cycle past wait so the first bit sets up
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      scl_hold_reg <= 1'b0;
    else
      scl_hold_reg <= (sl_reg == S_WAIT);
  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_scl_oe_n = ~((sl_reg == S_WAIT) | scl_hold_reg | m_scl_low_reg);
  assign bus.dev_sda_oe_n = ~(sl_sda_low_reg | m_sda_low_reg);
endmodule
`default_nettype wire

// ### i2cst_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module i2cst_asserts #(
  parameter int TOUT = 2000
)(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic host_scl_o,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  // ----------------------------------------
  // Host frame and clock-low tracking
  // ----------------------------------------
  logic act_reg;
  logic [15:0] low_reg;
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      act_reg <= 1'b0;
    else if (scl && $fell(host_sda_oe_n))
      act_reg <= 1'b1;
    else if (scl && $rose(host_sda_oe_n))
      act_reg <= 1'b0;
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      low_reg <= 16'h0000;
    else if (scl)
      low_reg <= 16'h0000;
    else if (low_reg != 16'hFFFF)
      low_reg <= low_reg + 16'h0001;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_rel;
    dev_scl_oe_n && dev_sda_oe_n;
  endsequence
  property p_od_dev;
    !dev_scl_o && !dev_sda_o;
  endproperty
  property p_od_host;
    !host_scl_o && !host_sda_o;
  endproperty
  property p_rst;
    !$past(arst_n) |-> s_rel;
  endproperty
  property p_setup;
    act_reg && $changed(dev_sda_oe_n) |-> !scl;
  endproperty
  property p_stretch;
    act_reg && $fell(dev_scl_oe_n) |-> !$past(scl);
  endproperty
  property p_tout;
    low_reg == TOUT + 8 |-> s_rel;
  endproperty
  property p_free;
    $fell(act_reg) |-> s_rel [*4];
  endproperty
  property p_ackhold;
    act_reg && scl && !dev_sda_oe_n |=> !dev_sda_oe_n || !scl;
  endproperty
  a_od_dev: assert property (p_od_dev) else $error("device drives a line high");
  a_od_host: assert property (p_od_host) else $error("host drives a line high");
  a_rst: assert property (p_rst) else $error("lines held after reset");
  a_setup: assert property (p_setup) else $error("data moved with clock high");
  a_stretch: assert property (p_stretch) else $error("clock pulled while high");
  a_tout: assert property (p_tout) else $error("bus kept after timeout");
  a_free: assert property (p_free) else $error("bus held after stop");
  a_ackhold: assert property (p_ackhold) else $error("low bit dropped early");
endmodule
`default_nettype wire

// ### i2cst_bench.sv
`timescale 1ns/100ps
`default_nettype none
module i2cst_bench
  import i2cst_pkg::*;
;
  localparam int TOUT = 2000;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic go = 1'b0;
  logic [6:0] rd_addr = 7'h00;
  logic [7:0] nbytes = 8'h01;
  logic hold_low = 1'b0;
  logic busy, rx_valid, addr_nack, done, nack_seen, fin;
  logic [7:0] reg_rdata, rx_data, s, b;
  logic [6:0] own;
  logic [31:0] seed = 32'h00008F87;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] exp_q[$];
  always #50 mclk = ~mclk;
  i2cst_bus_if bus_i ();
  i2cst_host #(.HALF(10)) i2cst_host_i (.mclk(mclk), .arst_n(arst_n), .bus(bus_i),
    .go(go), .rd_addr(rd_addr), .nbytes(nbytes), .hold_low(hold_low), .busy(busy),
    .rx_data(rx_data), .rx_valid(rx_valid), .addr_nack(addr_nack), .done(done));
  i2cst_device #(.HALF(10), .TOUT(TOUT)) i2cst_device_i (.mclk(mclk), .arst_n(arst_n),
    .bus(bus_i), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  i2cst_asserts #(.TOUT(TOUT)) i2cst_asserts_i (.mclk(mclk), .arst_n(arst_n),
    .dev_scl_o(bus_i.dev_scl_o), .dev_scl_oe_n(bus_i.dev_scl_oe_n),
    .dev_sda_o(bus_i.dev_sda_o), .dev_sda_oe_n(bus_i.dev_sda_oe_n),
    .host_scl_o(bus_i.host_scl_o), .host_scl_oe_n(bus_i.host_scl_oe_n),
    .host_sda_o(bus_i.host_sda_o), .host_sda_oe_n(bus_i.host_sda_oe_n),
    .scl(bus_i.scl), .sda(bus_i.sda));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic close_out();
    if (mismatches == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    s = reg_rdata;
  endtask
  task automatic wait_si();
    int k;
    k = 0;
    s = ST_IDLE;
    while (s === ST_IDLE && k < 3000)
    begin
      rd(REG_STATUS);
      k++;
    end
  endtask
  // Host read of n bytes; software loads up to last, then ends
  task automatic run(input logic [6:0] a, input int n, input int last, input bit stall,
    input bit nack, input logic [7:0] ctl_end);
    int i;
    int p;
    p = 0;
    nack_seen = 1'b0;
    fin = 1'b0;
    @(posedge mclk);
    rd_addr <= a;
    nbytes <= n[7:0];
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    for (i = 1; i <= last; i++)
    begin
      wait_si();
      cmp(s, (i == 1) ? ST_SLA_R_ACK : ST_TX_ACK);
      if (stall)
      begin
        repeat (TOUT + 50) @(posedge mclk);
        rd(REG_STATUS);
        cmp(s, ST_TIMEOUT);
        wr(REG_CTRL, ctl_end);
        last = 0;
      end
      else
      begin
        b = rnd();
        exp_q.push_back(b);
        p++;
        wr(REG_DATA, b);
        wr(REG_CTRL, (i < last) ? 8'h04 : 8'h00);
      end
    end
    if (last > 0)
    begin
      wait_si();
      cmp(s, (last == n) ? ST_TX_NACK : ST_LAST_ACK);
      wr(REG_CTRL, ctl_end);
    end
    for (i = p; i < n && !nack; i++)
      exp_q.push_back(8'hFF);
    for (i = 0; i < 5000 && !fin; i++)
      @(posedge mclk);
    cmp({6'h00, fin, busy}, 8'h02);
    cmp({7'h00, nack_seen}, {7'h00, nack});
    wr(REG_CTRL, ctl_end);
    rd(REG_STATUS);
    cmp(s, ST_IDLE);
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (addr_nack)
      nack_seen <= 1'b1;
    if (done)
      fin <= 1'b1;
    if (rx_valid)
      cmp(rx_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
    if (cycles == 60000)
    begin
      mismatches++;
      close_out();
    end
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    rd(REG_STATUS);
    cmp(s, ST_IDLE);
    rd(REG_ADDR);
    cmp(s, ADDR_RESET);
    rd(REG_DATA);
    cmp(s, DATA_RESET);
    b = rnd();
    own = {1'b0, b[5:0]} + 7'h08;
    wr(REG_ADDR, {own, 1'b0});
    wr(REG_CTRL, 8'h04);
    run(own, 1, 1, 1'b0, 1'b0, 8'h04);
    run(own, 3, 3, 1'b0, 1'b0, 8'h04);
    run(own, 2, 1, 1'b0, 1'b0, 8'h00);
    run(own, 1, 0, 1'b0, 1'b1, 8'h04);
    run(own ^ 7'h01, 1, 0, 1'b0, 1'b1, 8'h04);
    wr(REG_ADDR, {own, 1'b1});
    run(GEN_CALL_ADDR, 1, 0, 1'b0, 1'b0, 8'h04);
    wr(REG_ADDR, {own, 1'b0});
    run(GEN_CALL_ADDR, 1, 0, 1'b0, 1'b1, 8'h04);
    wr(REG_CTRL, 8'h24);
    repeat (400) @(posedge mclk);
    rd(REG_CTRL);
    cmp(s, 8'h04);
    run(own, 2, 2, 1'b1, 1'b0, 8'h04);
    @(posedge mclk);
    hold_low <= 1'b1;
    repeat (TOUT + 100) @(posedge mclk);
    rd(REG_STATUS);
    cmp(s, ST_TIMEOUT);
    hold_low <= 1'b0;
    wr(REG_CTRL, 8'h04);
    close_out();
  end
endmodule
`default_nettype wire
